// file: fpec_pkg.sv
// Package: register map, bit positions and types of the flash sequencer
package fpec_pkg;
    // Register byte addresses (word aligned)
    localparam logic [3:0] FPEC_ADDR_MODE = 4'h0;
    localparam logic [3:0] FPEC_ADDR_STAT = 4'h4;
    localparam logic [3:0] FPEC_ADDR_BLK = 4'h8;
    localparam logic [3:0] FPEC_ADDR_GATE = 4'hc;
    // Mode register bit positions
    localparam int FPEC_BIT_UNLOCK = 6;
    localparam int FPEC_BIT_ESU = 5;
    localparam int FPEC_BIT_PSU = 4;
    localparam int FPEC_BIT_EVFY = 3;
    localparam int FPEC_BIT_PVFY = 2;
    localparam int FPEC_BIT_ERASE = 1;
    localparam int FPEC_BIT_PROG = 0;
    // Status and gate bit positions
    localparam int FPEC_BIT_FAULT = 7;
    localparam int FPEC_BIT_GATE = 7;
    // Implemented bit masks
    localparam logic [7:0] FPEC_MODE_MASK = 8'h7f;
    localparam logic [4:0] FPEC_BLK_NONE = 5'h00;
    localparam logic [7:0] FPEC_RST8 = 8'h00;
    localparam logic [31:0] FPEC_RST32 = 32'h0000_0000;
    // Array geometry
    localparam logic [14:0] FPEC_BLK0_LO = 15'h0000;
    localparam logic [14:0] FPEC_BLK0_HI = 15'h03ff;
    localparam logic [14:0] FPEC_BLK1_LO = 15'h0400;
    localparam logic [14:0] FPEC_BLK1_HI = 15'h07ff;
    localparam logic [14:0] FPEC_BLK2_LO = 15'h0800;
    localparam logic [14:0] FPEC_BLK2_HI = 15'h0bff;
    localparam logic [14:0] FPEC_BLK3_LO = 15'h0c00;
    localparam logic [14:0] FPEC_BLK3_HI = 15'h0fff;
    localparam logic [14:0] FPEC_BLK4_LO = 15'h1000;
    localparam logic [14:0] FPEC_BLK4_HI = 15'h7fff;
    localparam int FPEC_UNIT_LSB = 7;
    localparam logic [6:0] FPEC_UNIT_OFS = 7'h00;

    // Array operating state
    typedef enum logic [2:0] {
        FPEC_READ = 3'b000,
        FPEC_PSETUP = 3'b001,
        FPEC_PROG = 3'b011,
        FPEC_PVFY = 3'b010,
        FPEC_ESETUP = 3'b110,
        FPEC_ERASE = 3'b111,
        FPEC_EVFY = 3'b101,
        FPEC_FAULT = 3'b100
    } fpec_state_t;

    // Array control bundle to the flash macro
    typedef struct packed {
        logic prog;
        logic erase;
        logic pvfy;
        logic evfy;
        logic [4:0] blk;
        logic [14:0] unit_addr;
    } fpec_arr_t;
endpackage

// file: fpec_ctrl.sv
// Flash program/erase control and status registers on Avalon-MM
//
// Operation
// - Program one aligned 128-byte unit per operation
// - Four 1k blocks, one 28k block
// - Unlock clear refuses other mode/block bits
// - Erase setup bit enters erase setup
// - Program setup bit enters program setup
// - Erase verify bit sets erase verify
// - Program verify bit sets program verify
// - Erase needs unlock and erase setup
// - Program needs unlock and program setup
// - Fault sets status bit 7, protects array
// - Unlock clear holds block select zero
// - Multiple block picks clear all picks
// - Block 4 covers 0x1000 to 0x7fff
// - Block 3 covers 0x0c00 to 0x0fff
// - Block 2 covers 0x0800 to 0x0bff
// - Block 1 covers 0x0400 to 0x07ff
// - Block 0 covers 0x0000 to 0x03ff
// - Reserved bits read as zero
// - Mode, status and block registers reachable only with access gate set
//
// The register addresses and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

module fpec_ctrl (
    input wire logic clk, // System clock, 40 MHz
    input wire logic resetn, // Asynchronous reset, active low
    input wire logic [3:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte lanes
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall until answer
    input wire logic [14:0] prog_addr, // Target address for programming
    input wire logic fault_event, // Error pulse from the array
    output fpec_pkg::fpec_arr_t arr_ctrl, // Controls to the array
    output fpec_pkg::fpec_state_t arr_state // Current array state
);
    import fpec_pkg::*;

    ////////////////////////////////////////////////////////////////////
    logic [7:0] mode_q;
    logic [7:0] mode_d;
    logic [4:0] blk_q;
    logic [4:0] blk_d;
    logic fault_q;
    logic gate_q;
    logic ack_q;
    logic [31:0] rdata_d;
    logic req;
    logic wr_go;
    logic rd_go;
    logic regs_open;
    logic fault_pending;
    logic fault_hit;
    fpec_state_t state_d;
    fpec_arr_t arr_d;

    // One wait state: the request is answered on the second edge
    assign req = avs_read | avs_write;
    assign wr_go = avs_write & ack_q;
    assign rd_go = avs_read & ack_q;
    assign regs_open = gate_q;
    // Only an error while programming or erasing counts as a fault
    assign fault_hit = fault_event &&
                       (arr_state == FPEC_PROG || arr_state == FPEC_ERASE);
    assign fault_pending = fault_q | fault_hit;

    // Answer toggle; waitrequest drops on the cycle after the request
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~(req & ~ack_q);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register access gate
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gate_q <= 1'b0;
        end else if (wr_go && avs_address == FPEC_ADDR_GATE &&
                     avs_byteenable[0]) begin
            gate_q <= avs_writedata[FPEC_BIT_GATE];
        end
    end

    // Mode register next value
    always_comb begin
        mode_d = mode_q;
        if (wr_go && regs_open && avs_address == FPEC_ADDR_MODE &&
            avs_byteenable[0]) begin
            mode_d = avs_writedata[7:0] & FPEC_MODE_MASK;
            if (!avs_writedata[FPEC_BIT_UNLOCK]) begin
                mode_d = FPEC_RST8;
            end else if (!mode_q[FPEC_BIT_UNLOCK]) begin
                mode_d = FPEC_RST8;
                mode_d[FPEC_BIT_UNLOCK] = 1'b1;
            end
        end
        if (fault_pending) begin
            mode_d[FPEC_BIT_ERASE] = 1'b0;
            mode_d[FPEC_BIT_PROG] = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_q <= FPEC_RST8;
        end else begin
            mode_q <= mode_d;
        end
    end

    // Block select next value
    always_comb begin
        blk_d = blk_q;
        if (wr_go && regs_open && avs_address == FPEC_ADDR_BLK &&
            avs_byteenable[0]) begin
            blk_d = avs_writedata[4:0];
        end
        if ($countones(blk_d) > 1) begin
            blk_d = FPEC_BLK_NONE;
        end
        if (!mode_d[FPEC_BIT_UNLOCK]) begin
            blk_d = FPEC_BLK_NONE;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            blk_q <= FPEC_BLK_NONE;
        end else begin
            blk_q <= blk_d;
        end
    end

    // Sticky fault flag; status register ignores writes
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fault_q <= 1'b0;
        end else if (fault_hit) begin
            fault_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Array state from the mode bits
    always_comb begin
        state_d = FPEC_READ;
        if (fault_q) begin
            state_d = FPEC_FAULT;
        end else if (mode_q[FPEC_BIT_UNLOCK]) begin
            if (mode_q[FPEC_BIT_ESU] && mode_q[FPEC_BIT_ERASE]) begin
                state_d = FPEC_ERASE;
            end else if (mode_q[FPEC_BIT_PSU] && mode_q[FPEC_BIT_PROG]) begin
                state_d = FPEC_PROG;
            end else if (mode_q[FPEC_BIT_ESU]) begin
                state_d = FPEC_ESETUP;
            end else if (mode_q[FPEC_BIT_PSU]) begin
                state_d = FPEC_PSETUP;
            end else if (mode_q[FPEC_BIT_EVFY]) begin
                state_d = FPEC_EVFY;
            end else if (mode_q[FPEC_BIT_PVFY]) begin
                state_d = FPEC_PVFY;
            end
        end
    end

    // Array controls follow the state
    always_comb begin
        arr_d = '0;
        case (state_d)
            FPEC_PROG: begin
                arr_d.prog = 1'b1;
                // Aligned 128-byte unit base
                arr_d.unit_addr = {prog_addr[14:FPEC_UNIT_LSB],
                                   FPEC_UNIT_OFS};
            end
            FPEC_ERASE: begin
                arr_d.erase = 1'b1;
                arr_d.blk = blk_q;
            end
            FPEC_PVFY: begin
                arr_d.pvfy = 1'b1;
            end
            FPEC_EVFY: begin
                arr_d.evfy = 1'b1;
                arr_d.blk = blk_q;
            end
            default: begin
                arr_d = '0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            arr_state <= FPEC_READ;
            arr_ctrl <= '0;
        end else begin
            arr_state <= state_d;
            arr_ctrl <= arr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read data mux; unmapped or gated reads return zero
    always_comb begin
        rdata_d = FPEC_RST32;
        case (avs_address)
            FPEC_ADDR_MODE: begin
                if (regs_open) begin
                    rdata_d[7:0] = mode_q;
                end
            end
            FPEC_ADDR_STAT: begin
                if (regs_open) begin
                    rdata_d[FPEC_BIT_FAULT] = fault_q;
                end
            end
            FPEC_ADDR_BLK: begin
                if (regs_open) begin
                    rdata_d[4:0] = blk_q;
                end
            end
            FPEC_ADDR_GATE: begin
                rdata_d[FPEC_BIT_GATE] = gate_q;
            end
            default: begin
                rdata_d = FPEC_RST32;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            avs_readdata <= FPEC_RST32;
        end else if (avs_read && !ack_q) begin
            avs_readdata <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Block address ranges, for reference by checks
    logic [14:0] blk_lo [5];
    logic [14:0] blk_hi [5];
    assign blk_lo[0] = FPEC_BLK0_LO;
    assign blk_hi[0] = FPEC_BLK0_HI;
    assign blk_lo[1] = FPEC_BLK1_LO;
    assign blk_hi[1] = FPEC_BLK1_HI;
    assign blk_lo[2] = FPEC_BLK2_LO;
    assign blk_hi[2] = FPEC_BLK2_HI;
    assign blk_lo[3] = FPEC_BLK3_LO;
    assign blk_hi[3] = FPEC_BLK3_HI;
    assign blk_lo[4] = FPEC_BLK4_LO;
    assign blk_hi[4] = FPEC_BLK4_HI;

    // Checks
    unlock_gates_a: assert property (
        @(posedge clk) disable iff (!resetn)
        !mode_q[FPEC_BIT_UNLOCK] |-> (mode_q == FPEC_RST8))
        else $error("mode bits set while locked");

    blk_zero_a: assert property (
        @(posedge clk) disable iff (!resetn)
        !mode_q[FPEC_BIT_UNLOCK] |-> (blk_q == FPEC_BLK_NONE))
        else $error("block select not zero while locked");

    blk_onehot_a: assert property (
        @(posedge clk) disable iff (!resetn)
        $onehot0(blk_q))
        else $error("more than one block selected");

    erase_entry_a: assert property (
        @(posedge clk) disable iff (!resetn)
        arr_ctrl.erase |-> $past(mode_q[FPEC_BIT_ESU] &&
                                 mode_q[FPEC_BIT_UNLOCK]))
        else $error("erase without setup");

    prog_entry_a: assert property (
        @(posedge clk) disable iff (!resetn)
        arr_ctrl.prog |-> $past(mode_q[FPEC_BIT_PSU] &&
                                mode_q[FPEC_BIT_UNLOCK]))
        else $error("program without setup");

    prog_align_a: assert property (
        @(posedge clk) disable iff (!resetn)
        arr_ctrl.prog |-> (arr_ctrl.unit_addr[6:0] == FPEC_UNIT_OFS))
        else $error("program unit not aligned");

    fault_sticky_a: assert property (
        @(posedge clk) disable iff (!resetn)
        fault_q |=> fault_q && (arr_state == FPEC_FAULT) && !arr_ctrl.prog)
        else $error("fault protection lost");

    evfy_mode_a: assert property (
        @(posedge clk) disable iff (!resetn)
        (mode_q == 8'h48) && !fault_q |=> arr_ctrl.evfy)
        else $error("erase verify not entered");

    pvfy_mode_a: assert property (
        @(posedge clk) disable iff (!resetn)
        (mode_q == 8'h44) && !fault_q |=> arr_ctrl.pvfy)
        else $error("program verify not entered");

    reserved_a: assert property (
        @(posedge clk) disable iff (!resetn)
        !avs_waitrequest |-> (avs_readdata[31:8] == 24'h000000))
        else $error("reserved bits read nonzero");

    answer_time_a: assert property (
        @(posedge clk) disable iff (!resetn)
        $rose(avs_read | avs_write) |-> ##1 !avs_waitrequest)
        else $error("bus answer late");

    wait_pulse_a: assert property (
        @(posedge clk) disable iff (!resetn)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");

    gate_blk_a: assert property (
        @(posedge clk) disable iff (!resetn)
        !regs_open |=> $stable(blk_q))
        else $error("block select changed while gated");

    gated_read_a: assert property (
        @(posedge clk) disable iff (!resetn)
        avs_read && !ack_q && !regs_open &&
        (avs_address != FPEC_ADDR_GATE) |=> (avs_readdata == FPEC_RST32))
        else $error("gated register read not zero");

    blk_tiling_a: assert property (
        @(posedge clk) disable iff (!resetn)
        (blk_lo[0] == '0) && (&blk_hi[4]) &&
        (blk_lo[1] == blk_hi[0] + 15'h0001) &&
        (blk_lo[2] == blk_hi[1] + 15'h0001) &&
        (blk_lo[3] == blk_hi[2] + 15'h0001) &&
        (blk_lo[4] == blk_hi[3] + 15'h0001))
        else $error("erase blocks do not tile the array");
endmodule // fpec_ctrl

`default_nettype wire

// file: tb_fpec_ctrl.sv
// Testbench: register model comparison of the flash sequencer
`timescale 1ns/1ps
`default_nettype none

module tb_fpec_ctrl;
    import fpec_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [14:0] prog_addr = 15'h0000;
    logic fault_event = 1'b0;
    fpec_arr_t arr_ctrl;
    fpec_state_t arr_state;
    int n_errors = 0;
    int samples_checked = 0;
    logic [7:0] mode_m = 8'h00;
    logic [7:0] blk_m = 8'h00;
    logic gate_m = 1'b0;
    logic fault_m = 1'b0;
    logic [31:0] rdata;
    int pick;

    fpec_ctrl fpec_ctrl_i (.clk(clk), .resetn(resetn),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .prog_addr(prog_addr),
        .fault_event(fault_event), .arr_ctrl(arr_ctrl),
        .arr_state(arr_state));

    ////////////////////////////////////////////////////////////////////////
    // Clock, 25 ns period
    initial begin
        forever #12.5 clk = ~clk;
    end

    // Comparison with counting
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h",
                     $time, what, got, exp);
        end
    endtask

    // Expected read value of the register model
    function automatic logic [31:0] model_rd(input logic [3:0] a);
        model_rd = 32'h0000_0000;
        if (a == FPEC_ADDR_GATE) model_rd = {24'h0, gate_m, 7'h00};
        else if (gate_m && a == FPEC_ADDR_MODE) model_rd = {24'h0, mode_m};
        else if (gate_m && a == FPEC_ADDR_STAT)
            model_rd = {24'h0, fault_m, 7'h00};
        else if (gate_m && a == FPEC_ADDR_BLK) model_rd = {24'h0, blk_m};
    endfunction

    // Expected array state of the model
    function automatic fpec_state_t model_st();
        if (fault_m) return FPEC_FAULT;
        if (mode_m[6] && mode_m[5] && mode_m[1]) return FPEC_ERASE;
        if (mode_m[6] && mode_m[4] && mode_m[0]) return FPEC_PROG;
        if (mode_m[5]) return FPEC_ESETUP;
        if (mode_m[4]) return FPEC_PSETUP;
        if (mode_m[3]) return FPEC_EVFY;
        if (mode_m[2]) return FPEC_PVFY;
        return FPEC_READ;
    endfunction

    // One Avalon-MM transfer, held until waitrequest is sampled low
    task automatic bus(input logic rw, input logic [3:0] a,
                       input logic [7:0] d, input logic [3:0] be);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        avs_write <= rw;
        avs_read <= ~rw;
        // Only the watchdog ends a wait that never gets an answer
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    // Register write, then the same write applied to the model
    task automatic wr(input logic [3:0] a, input logic [7:0] d,
                      input logic [3:0] be = 4'h1);
        bus(1'b1, a, d, be);
        if (be[0]) begin
            if (a == FPEC_ADDR_GATE) gate_m = d[7];
            else if (gate_m && a == FPEC_ADDR_MODE) begin
                if (!d[6]) mode_m = 8'h00;
                else if (!mode_m[6]) mode_m = 8'h40;
                else mode_m = d & FPEC_MODE_MASK;
                if (!mode_m[6]) blk_m = 8'h00;
            end else if (gate_m && a == FPEC_ADDR_BLK) begin
                blk_m = (mode_m[6] && $countones(d[4:0]) < 2) ?
                        {3'h0, d[4:0]} : 8'h00;
            end
        end
    endtask

    // Register read compared with the model
    task automatic rd(input logic [3:0] a);
        bus(1'b0, a, 8'h00, 4'hf);
        cmp(rdata, model_rd(a), "register read");
    endtask

    // Array outputs compared once the register change has settled
    task automatic chk_out();
        fpec_state_t st;
        repeat (3) @(posedge clk);
        #1;
        st = model_st();
        cmp({29'h0, arr_state}, {29'h0, st}, "array state");
        cmp({31'h0, arr_ctrl.prog}, {31'h0, st == FPEC_PROG}, "prog");
        cmp({31'h0, arr_ctrl.erase}, {31'h0, st == FPEC_ERASE}, "erase");
        cmp({31'h0, arr_ctrl.pvfy}, {31'h0, st == FPEC_PVFY}, "pvfy");
        cmp({31'h0, arr_ctrl.evfy}, {31'h0, st == FPEC_EVFY}, "evfy");
        // Block picks reach the array only while erasing or erase verifying
        cmp({27'h0, arr_ctrl.blk},
            {27'h0, (st == FPEC_ERASE || st == FPEC_EVFY) ?
                    blk_m[4:0] : 5'h00}, "block");
        if (st == FPEC_PROG)
            cmp({17'h0, arr_ctrl.unit_addr},
                {17'h0, prog_addr[14:7], 7'h00}, "unit address");
    endtask

    // Error pulse from the array; latched only while programming or erasing
    task automatic pulse();
        fpec_state_t st;
        st = model_st();
        @(posedge clk);
        fault_event <= 1'b1;
        @(posedge clk);
        fault_event <= 1'b0;
        if (st == FPEC_PROG || st == FPEC_ERASE) begin
            fault_m = 1'b1;
            mode_m = mode_m & 8'hfc;
        end
    endtask

    task automatic do_reset(input int cyc);
        @(posedge clk);
        resetn <= 1'b0;
        repeat (cyc) @(posedge clk);
        resetn <= 1'b1;
        mode_m = 8'h00;
        blk_m = 8'h00;
        gate_m = 1'b0;
        fault_m = 1'b0;
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial begin
        #2000000;
        n_errors++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        report_and_stop();
    end

    // Main sequence
    initial begin
        pick = $urandom(32'h67131c60);
        do_reset(12);
        for (int a = 0; a < 16; a += 4) rd(a[3:0]);
        wr(FPEC_ADDR_MODE, 8'h40);
        wr(FPEC_ADDR_GATE, 8'h80);
        for (int a = 0; a < 16; a += 4) rd(a[3:0]);
        chk_out();
        $display("Test reset and gate done");
        wr(FPEC_ADDR_BLK, 8'h01);
        rd(FPEC_ADDR_BLK);
        wr(FPEC_ADDR_MODE, 8'h7f);
        rd(FPEC_ADDR_MODE);
        wr(FPEC_ADDR_MODE, 8'hc0);
        rd(FPEC_ADDR_MODE);
        for (int b = 2; b < 6; b++) begin
            wr(FPEC_ADDR_MODE, 8'h40 | (8'h01 << b));
            rd(FPEC_ADDR_MODE);
            chk_out();
            wr(FPEC_ADDR_MODE, 8'h40);
            chk_out();
        end
        $display("Test unlock and modes done");
        prog_addr <= 15'($urandom);
        wr(FPEC_ADDR_MODE, 8'h41);
        chk_out();
        wr(FPEC_ADDR_MODE, 8'h50);
        wr(FPEC_ADDR_MODE, 8'h51);
        chk_out();
        wr(FPEC_ADDR_MODE, 8'h50);
        chk_out();
        wr(FPEC_ADDR_MODE, 8'h42);
        chk_out();
        wr(FPEC_ADDR_MODE, 8'h60);
        wr(FPEC_ADDR_MODE, 8'h62);
        chk_out();
        wr(FPEC_ADDR_MODE, 8'h40);
        chk_out();
        $display("Test program and erase done");
        wr(FPEC_ADDR_MODE, 8'h60);
        wr(FPEC_ADDR_MODE, 8'h62);
        for (int i = 0; i < 5; i++) begin
            wr(FPEC_ADDR_BLK, 8'h01 << i);
            rd(FPEC_ADDR_BLK);
            chk_out();
        end
        for (int i = 0; i < 12; i++) begin
            pick = $urandom;
            wr(FPEC_ADDR_BLK, pick[7:0]);
            rd(FPEC_ADDR_BLK);
        end
        wr(FPEC_ADDR_BLK, 8'he4);
        rd(FPEC_ADDR_BLK);
        wr(FPEC_ADDR_BLK, 8'h03);
        rd(FPEC_ADDR_BLK);
        wr(FPEC_ADDR_BLK, 8'h08);
        wr(FPEC_ADDR_MODE, 8'h00);
        rd(FPEC_ADDR_BLK);
        chk_out();
        $display("Test block select done");
        rd(FPEC_ADDR_STAT);
        wr(4'h2, 8'hff);
        rd(4'h1);
        wr(FPEC_ADDR_GATE, 8'h00, 4'h0);
        rd(FPEC_ADDR_GATE);
        wr(FPEC_ADDR_MODE, 8'h40);
        wr(FPEC_ADDR_MODE, 8'h50);
        pulse();
        rd(FPEC_ADDR_STAT);
        prog_addr <= 15'($urandom);
        wr(FPEC_ADDR_MODE, 8'h51);
        chk_out();
        pulse();
        rd(FPEC_ADDR_STAT);
        rd(FPEC_ADDR_MODE);
        chk_out();
        $display("Test status and fault done");
        do_reset(3);
        for (int a = 0; a < 16; a += 4) rd(a[3:0]);
        chk_out();
        $display("Test second reset done");
        report_and_stop();
    end
endmodule // tb_fpec_ctrl

`default_nettype wire
